/* core/fsc_setup_abort.v */
// Purpose: user setup, abort capture, abort permit and ecc config regs
// Assumes: one clock, synchronous reset, single-cycle register port
// Notes: read data appear in the cycle after the read strobe only
//
// What this block does
// [RULE1] read-only management flag bit 4, resets 1
// [RULE2] swap bit 3 swaps user flash arrays
// [RULE3] bit 2 auto-advance, bit 1 keyhole dma
// [RULE4] debug access only while bit 0 set
// [RULE5] kernel completion sets debug enable
// [RULE6] upper setup bits read as zero
// [RULE7] abort captures address being written
// [RULE8] software reads capture before next command
// [RULE9] capture register has no reset value
// [RULE10] low permit map gates interrupt aborts
// [RULE11] high map covers interrupts 32 to 54
// [RULE12] ecc config writable only after ecc key
// [RULE13] ecc config write clears the key
// [RULE14] user setup writable only under general key
// [RULE15] key register reads as zero
// [RULE16] locked writes are ignored
// [RULE17] permit maps reset to zero
`timescale 1ns/1ps
`include "fsc_regs.vh"

module fsc_setup_abort (
  input wire CLOCK, // system clock, 200 MHz
  input wire RESET, // synchronous reset, active high
  input wire [31:0] ADDR, // register byte address
  input wire [31:0] WDATA, // register write data
  input wire WR, // write strobe, one cycle
  input wire RD, // read strobe, one cycle
  output reg [31:0] RDATA, // read data, cycle after RD
  input wire MGMT_MODE, // management mode level from the device
  input wire KERNEL_DONE, // pulse when the boot kernel finishes
  input wire SWD_REQ, // debug port access request
  output reg SWD_GRANT, // debug port access allowed
  output reg ADDR_SWAP, // user flash array 0 and 1 swapped
  output reg AUTO_ADVANCE, // keyhole location auto-advance active
  output reg KEYHOLE_DMA, // keyhole dma mode
  input wire WRITE_ABORTED, // pulse: a flash write was aborted
  input wire [31:0] WRITE_LOCATION, // location being written
  input wire [`FSC_IRQ_W-1:0] IRQ, // pending system interrupts
  input wire CMD_ACTIVE, // write, erase, sign or verify running
  output wire CMD_ABORT, // abort request to the command engine
  output reg [`FSC_ECC_CFG_W-1:0] ECC_CFG // ecc error response config
);

  // register write decode
  wire wr_key;
  wire wr_setup;
  wire wr_aen_low;
  wire wr_aen_high;
  wire wr_ecc;
  wire gen_key_on;
  wire ecc_key_on;
  wire ecc_wr_ok;

  assign wr_key = WR & (ADDR == `FSC_ADDR_UNLOCK_KEY);
  assign wr_setup = WR & (ADDR == `FSC_ADDR_USER_SETUP);
  assign wr_aen_low = WR & (ADDR == `FSC_ADDR_AEN_LOW);
  assign wr_aen_high = WR & (ADDR == `FSC_ADDR_AEN_HIGH);
  assign wr_ecc = WR & (ADDR == `FSC_ADDR_ECC_CFG);
  assign ecc_wr_ok = wr_ecc & ecc_key_on; // [RULE12]

  // control state
  reg mgmt_ff;
  reg swap_ff;
  reg auto_adv_ff;
  reg kh_dma_ff;
  reg dbg_en_ff;
  reg [31:0] aen_low_ff;
  reg [`FSC_AEN_HIGH_W-1:0] aen_high_ff;
  reg [31:0] abort_loc_ff;

  fsc_keyguard u_keyguard (
    .clk(CLOCK),
    .rst(RESET),
    .key_wr(wr_key),
    .key_data(WDATA),
    .ecc_cfg_wr(ecc_wr_ok),
    .gen_key_on(gen_key_on),
    .ecc_key_on(ecc_key_on)
  );

  fsc_abort_gate u_abort_gate (
    .clk(CLOCK),
    .rst(RESET),
    .permit_low(aen_low_ff),
    .permit_high(aen_high_ff),
    .irq(IRQ),
    .cmd_active(CMD_ACTIVE),
    .abort_req(CMD_ABORT)
  );

  // management flag follows the device level once out of reset
  always @(posedge CLOCK) begin
    if (RESET) begin
      mgmt_ff <= `FSC_RST_MGMT_MODE; // [RULE1]
    end else begin
      mgmt_ff <= MGMT_MODE;
    end
  end

  // user setup fields; locked writes leave them untouched
  always @(posedge CLOCK) begin
    if (RESET) begin
      swap_ff <= `FSC_RST_SWAP;
      auto_adv_ff <= `FSC_RST_AUTO_ADV;
      kh_dma_ff <= `FSC_RST_KH_DMA;
      dbg_en_ff <= `FSC_RST_DEBUG_EN;
    end else begin
      if (wr_setup && gen_key_on) begin // [RULE14] [RULE16]
        swap_ff <= WDATA[`FSC_BIT_SWAP];
        auto_adv_ff <= WDATA[`FSC_BIT_AUTO_ADV];
        kh_dma_ff <= WDATA[`FSC_BIT_KH_DMA];
        dbg_en_ff <= WDATA[`FSC_BIT_DEBUG_EN];
      end
      // kernel completion wins over a same-cycle write of zero
      if (KERNEL_DONE) begin
        dbg_en_ff <= 1'b1; // [RULE5]
      end
    end
  end

  // abort permit maps
  always @(posedge CLOCK) begin
    if (RESET) begin
      aen_low_ff <= `FSC_RST_AEN_LOW; // [RULE17]
      aen_high_ff <= `FSC_RST_AEN_HIGH; // [RULE17]
    end else begin
      if (wr_aen_low) begin
        aen_low_ff <= WDATA; // [RULE10]
      end
      if (wr_aen_high) begin
        aen_high_ff <= WDATA[`FSC_AEN_HIGH_W-1:0]; // [RULE11]
      end
    end
  end

  // ecc config, accepted only with the ecc key active
  always @(posedge CLOCK) begin
    if (RESET) begin
      ECC_CFG <= `FSC_RST_ECC_CFG;
    end else if (ecc_wr_ok) begin // [RULE12] [RULE16]
      ECC_CFG <= WDATA[`FSC_ECC_CFG_W-1:0];
    end
  end

  // capture has no reset on purpose; it is only valid after an abort
  always @(posedge CLOCK) begin
    if (WRITE_ABORTED) begin
      abort_loc_ff <= WRITE_LOCATION; // [RULE7] [RULE9]
    end
  end

  // derived controls, all registered
  always @(posedge CLOCK) begin
    if (RESET) begin
      ADDR_SWAP <= 1'b0;
      AUTO_ADVANCE <= 1'b0;
      KEYHOLE_DMA <= 1'b0;
      SWD_GRANT <= 1'b0;
    end else begin
      // swap only takes effect in management mode
      ADDR_SWAP <= swap_ff & mgmt_ff; // [RULE1] [RULE2]
      // auto-advance is a non-dma feature only
      AUTO_ADVANCE <= auto_adv_ff & ~kh_dma_ff; // [RULE3]
      KEYHOLE_DMA <= kh_dma_ff; // [RULE3]
      SWD_GRANT <= SWD_REQ & dbg_en_ff; // [RULE4]
    end
  end

  // read mux
  reg [31:0] nxt_rdata;

  always @* begin
    nxt_rdata = 32'h00000000;
    case (ADDR)
      `FSC_ADDR_USER_SETUP: begin
        nxt_rdata[`FSC_BIT_MGMT_MODE] = mgmt_ff; // [RULE6]
        nxt_rdata[`FSC_BIT_SWAP] = swap_ff;
        nxt_rdata[`FSC_BIT_AUTO_ADV] = auto_adv_ff;
        nxt_rdata[`FSC_BIT_KH_DMA] = kh_dma_ff;
        nxt_rdata[`FSC_BIT_DEBUG_EN] = dbg_en_ff;
      end
      `FSC_ADDR_ABORT_LOC: begin
        nxt_rdata = abort_loc_ff;
      end
      `FSC_ADDR_AEN_LOW: begin
        nxt_rdata = aen_low_ff;
      end
      `FSC_ADDR_AEN_HIGH: begin
        nxt_rdata[`FSC_AEN_HIGH_W-1:0] = aen_high_ff;
      end
      `FSC_ADDR_ECC_CFG: begin
        nxt_rdata[`FSC_ECC_CFG_W-1:0] = ECC_CFG;
      end
      `FSC_ADDR_KEY_STATUS: begin
        nxt_rdata[1] = ecc_key_on;
        nxt_rdata[0] = gen_key_on;
      end
      `FSC_ADDR_UNLOCK_KEY: begin
        nxt_rdata = 32'h00000000; // [RULE15]
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always @(posedge CLOCK) begin
    if (RESET) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      RDATA <= nxt_rdata;
    end else begin
      RDATA <= 32'h00000000;
    end
  end

endmodule

/* core/fsc_regs.vh */
// Purpose: constants of the flash setup and abort-control block
// Assumes: 32-bit register bus with full byte addresses
// Notes: definitions only
`ifndef FSC_REGS_VH
`define FSC_REGS_VH

`define FSC_ADDR_UNLOCK_KEY 32'h40018020
`define FSC_ADDR_USER_SETUP 32'h40018038
`define FSC_ADDR_ABORT_LOC 32'h40018040
`define FSC_ADDR_AEN_LOW 32'h40018048
`define FSC_ADDR_AEN_HIGH 32'h4001804c
`define FSC_ADDR_ECC_CFG 32'h40018064
`define FSC_ADDR_KEY_STATUS 32'h400180f0

`define FSC_KEY_GENERAL 32'hf123f456
`define FSC_KEY_ECC 32'h5eccacce

`define FSC_BIT_MGMT_MODE 4
`define FSC_BIT_SWAP 3
`define FSC_BIT_AUTO_ADV 2
`define FSC_BIT_KH_DMA 1
`define FSC_BIT_DEBUG_EN 0

`define FSC_RST_MGMT_MODE 1'h1
`define FSC_RST_SWAP 1'h0
`define FSC_RST_AUTO_ADV 1'h0
`define FSC_RST_KH_DMA 1'h0
`define FSC_RST_DEBUG_EN 1'h0
`define FSC_RST_AEN_LOW 32'h00000000
`define FSC_RST_AEN_HIGH 23'h000000
`define FSC_RST_ECC_CFG 5'h00

`define FSC_AEN_HIGH_W 23
`define FSC_IRQ_W 55
`define FSC_ECC_CFG_W 5

`endif

/* core/fsc_keyguard.v */
// Purpose: unlock key tracking for the protected registers
// Assumes: key_wr is a one-cycle strobe for a key register write
// Notes: both key states come straight from flip-flops
`timescale 1ns/1ps
`include "fsc_regs.vh"

module fsc_keyguard (
  input wire clk, // system clock
  input wire rst, // synchronous reset, active high
  input wire key_wr, // write strobe to the key register
  input wire [31:0] key_data, // value written to the key register
  input wire ecc_cfg_wr, // accepted write to the ecc config register
  output reg gen_key_on, // general key active
  output reg ecc_key_on // ecc key active
);

  always @(posedge clk) begin
    if (rst) begin
      gen_key_on <= 1'b0;
      ecc_key_on <= 1'b0;
    end else if (key_wr) begin
      // any other value relocks; user setup writes never relock
      gen_key_on <= (key_data == `FSC_KEY_GENERAL); // [RULE14]
      ecc_key_on <= (key_data == `FSC_KEY_ECC); // [RULE12]
    end else if (ecc_cfg_wr) begin
      ecc_key_on <= 1'b0; // [RULE13]
    end
  end

endmodule

/* core/fsc_abort_gate.v */
// Purpose: decide whether a pending interrupt aborts a running command
// Assumes: irq levels and cmd_active are synchronous to clk
// Notes: one cycle of latency from irq to abort_req
`timescale 1ns/1ps
`include "fsc_regs.vh"

module fsc_abort_gate (
  input wire clk, // system clock
  input wire rst, // synchronous reset, active high
  input wire [31:0] permit_low, // permit bits for interrupts 0..31
  input wire [`FSC_AEN_HIGH_W-1:0] permit_high, // interrupts 32..54
  input wire [`FSC_IRQ_W-1:0] irq, // pending system interrupts
  input wire cmd_active, // abortable command is running
  output reg abort_req // request to abort the running command
);

  wire [`FSC_IRQ_W-1:0] permit;
  assign permit = {permit_high, permit_low};

  always @(posedge clk) begin
    if (rst) begin
      abort_req <= 1'b0;
    end else begin
      abort_req <= cmd_active & (|(irq & permit)); // [RULE10] [RULE11]
    end
  end

endmodule

/* bench/fsc_props.sv */
// Purpose: port checks for fsc_setup_abort
// Assumes: synchronous active-high reset
// Notes: bound to every instance
`timescale 1ns/1ps
`include "fsc_regs.vh"
module fsc_props (
  input wire CLOCK, // clock
  input wire RESET, // reset
  input wire [31:0] ADDR, // address
  input wire WR, // write
  input wire RD, // read
  input wire [31:0] RDATA, // data out
  input wire MGMT_MODE, // mgmt
  input wire KERNEL_DONE, // boot end
  input wire SWD_REQ, // dbg req
  input wire SWD_GRANT, // dbg ok
  input wire ADDR_SWAP, // swap
  input wire AUTO_ADVANCE, // adv
  input wire KEYHOLE_DMA, // dma
  input wire [`FSC_IRQ_W-1:0] IRQ, // irqs
  input wire CMD_ACTIVE, // busy
  input wire CMD_ABORT, // abort
  input wire [`FSC_ECC_CFG_W-1:0] ECC_CFG // ecc
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_grant_req:
  assert property (SWD_GRANT |-> $past(SWD_REQ)) else $error("bad grant");
  a_abort_cause:
  assert property (CMD_ABORT |-> $past(CMD_ACTIVE && |IRQ))
    else $error("abort without cause");
  a_dma_adv:
  assert property (KEYHOLE_DMA |-> !AUTO_ADVANCE) else $error("adv in dma");
  a_swap_mgmt:
  assert property (ADDR_SWAP |-> $past(MGMT_MODE, 2)) else $error("swap");
  a_key_zero:
  assert property (RD && ADDR == `FSC_ADDR_UNLOCK_KEY |=> RDATA == 0)
    else $error("key readable");
  a_setup_upper:
  assert property (RD && ADDR == `FSC_ADDR_USER_SETUP |=> RDATA[31:5] == 0)
    else $error("upper bits set");
  a_ecc_lock:
  assert property ($changed(ECC_CFG) |-> $past(WR && ADDR == `FSC_ADDR_ECC_CFG))
    else $error("ecc changed");
  a_ecc_relock:
  assert property (WR && ADDR == `FSC_ADDR_ECC_CFG ##1
    WR && ADDR == `FSC_ADDR_ECC_CFG |=> $stable(ECC_CFG)) else $error("relock");
  a_kernel_dbg:
  assert property (KERNEL_DONE ##1 SWD_REQ |=> SWD_GRANT) else $error("dbg");
endmodule
bind fsc_setup_abort fsc_props i_fsc_props (.CLOCK, .RESET, .ADDR, .WR,
  .RD, .RDATA, .MGMT_MODE, .KERNEL_DONE, .SWD_REQ, .SWD_GRANT, .ADDR_SWAP,
  .AUTO_ADVANCE, .KEYHOLE_DMA, .IRQ, .CMD_ACTIVE, .CMD_ABORT, .ECC_CFG);

/* bench/fsc_cmd_model.sv */
// Purpose: flash command engine model facing the abort logic
// Assumes: start is a one-cycle pulse
// Notes: a command runs LEN cycles unless aborted
`timescale 1ns/1ps
module fsc_cmd_model #(parameter int LEN = 32) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic start, // begin a write
  input wire logic [31:0] loc, // location
  input wire logic abort, // abort request
  output logic active, // running
  output logic aborted, // abort pulse
  output logic [31:0] location // location written
);
  int left_ff;
  always @(posedge clk) begin
    aborted <= 0;
    if (rst) begin
      active <= 0;
      location <= 0;
    end else if (start) begin
      active <= 1;
      left_ff <= LEN;
      location <= loc;
    end else if (active && abort) begin
      active <= 0;
      aborted <= 1;
    end else if (active) begin
      left_ff <= left_ff - 1;
      active <= left_ff > 1;
    end else begin
      // idle bus must not keep showing the old location
      location <= ~location;
    end
  end
endmodule

/* bench/fsc_setup_abort_tb.sv */
// Purpose: directed bench for fsc_setup_abort
// Assumes: command engine model on the far side
// Notes: register traffic through wr and rd tasks
`timescale 1ns/1ps
`include "fsc_regs.vh"
module fsc_setup_abort_tb;
  logic CLOCK = 0, RESET = 1, WR = 0, RD = 0, MGMT_MODE = 1;
  logic KERNEL_DONE = 0, SWD_REQ = 0, start = 0;
  logic [31:0] ADDR = 0, WDATA = 0, RDATA, loc = 0, WRITE_LOCATION;
  logic [`FSC_IRQ_W-1:0] IRQ = 0;
  logic [`FSC_ECC_CFG_W-1:0] ECC_CFG;
  logic SWD_GRANT, ADDR_SWAP, AUTO_ADVANCE, KEYHOLE_DMA;
  logic WRITE_ABORTED, CMD_ACTIVE, CMD_ABORT;
  logic [63:0] m;
  int failures = 0, compares = 0, cycles = 0;
  int vec[4] = '{0, 31, 32, 54};
  always #2.5 CLOCK = ~CLOCK;
  fsc_setup_abort i_fsc_setup_abort (.CLOCK, .RESET, .ADDR, .WDATA, .WR,
    .RD, .RDATA, .MGMT_MODE, .KERNEL_DONE, .SWD_REQ, .SWD_GRANT, .ADDR_SWAP,
    .AUTO_ADVANCE, .KEYHOLE_DMA, .WRITE_ABORTED, .WRITE_LOCATION, .IRQ,
    .CMD_ACTIVE, .CMD_ABORT, .ECC_CFG);
  fsc_cmd_model i_fsc_cmd_model (.clk(CLOCK), .rst(RESET), .start, .loc,
    .abort(CMD_ABORT), .active(CMD_ACTIVE), .aborted(WRITE_ABORTED),
    .location(WRITE_LOCATION));
  task complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [31:0] a, d);
    {ADDR, WDATA, WR, RD} <= {a, d, 2'b10};
    @(posedge CLOCK);
  endtask
  task rd(input logic [31:0] a, exp);
    {ADDR, WR, RD} <= {a, 2'b01};
    @(posedge CLOCK);
    {WR, RD} <= 2'b00;
    #1 chk(RDATA, exp);
    @(posedge CLOCK);
  endtask
  task nop(input int n);
    {WR, RD} <= 2'b00;
    repeat (n) @(posedge CLOCK);
  endtask
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge CLOCK);
    RESET <= 0;
    nop(1);
    rd(`FSC_ADDR_USER_SETUP, 32'h10);
    rd(`FSC_ADDR_AEN_LOW, 0);
    rd(`FSC_ADDR_AEN_HIGH, 0);
    wr(`FSC_ADDR_USER_SETUP, 32'hf);
    rd(`FSC_ADDR_USER_SETUP, 32'h10);
    rd(`FSC_ADDR_UNLOCK_KEY, 0);
    wr(`FSC_ADDR_UNLOCK_KEY, `FSC_KEY_GENERAL);
    rd(`FSC_ADDR_KEY_STATUS, 32'h1);
    wr(`FSC_ADDR_USER_SETUP, 32'hffffffff);
    rd(`FSC_ADDR_USER_SETUP, 32'h1f);
    chk({ADDR_SWAP, AUTO_ADVANCE, KEYHOLE_DMA}, 3'b101);
    SWD_REQ <= 1;
    MGMT_MODE <= 0;
    wr(`FSC_ADDR_USER_SETUP, 32'hd);
    rd(`FSC_ADDR_USER_SETUP, 32'h0d);
    chk({ADDR_SWAP, AUTO_ADVANCE, KEYHOLE_DMA, SWD_GRANT}, 4'b0101);
    MGMT_MODE <= 1;
    nop(3);
    chk(ADDR_SWAP, 1);
    wr(`FSC_ADDR_USER_SETUP, 32'h4);
    nop(3);
    chk({ADDR_SWAP, SWD_GRANT}, 2'b00);
    KERNEL_DONE <= 1;
    nop(1);
    KERNEL_DONE <= 0;
    nop(2);
    chk(SWD_GRANT, 1);
    wr(`FSC_ADDR_UNLOCK_KEY, 0);
    wr(`FSC_ADDR_USER_SETUP, 0);
    rd(`FSC_ADDR_USER_SETUP, 32'h15);
    wr(`FSC_ADDR_ECC_CFG, 32'h1f);
    wr(`FSC_ADDR_UNLOCK_KEY, `FSC_KEY_ECC);
    rd(`FSC_ADDR_KEY_STATUS, 32'h2);
    wr(`FSC_ADDR_ECC_CFG, 32'h1f);
    wr(`FSC_ADDR_ECC_CFG, 32'h00);
    rd(`FSC_ADDR_ECC_CFG, 32'h1f);
    chk(ECC_CFG, 5'h1f);
    rd(`FSC_ADDR_KEY_STATUS, 32'h0);
    foreach (vec[i]) begin
      m = 64'h1 << vec[i];
      wr(`FSC_ADDR_AEN_LOW, m[31:0]);
      wr(`FSC_ADDR_AEN_HIGH, m[63:32]);
      loc <= 32'h100 + vec[i];
      start <= 1;
      IRQ <= {m[53:0], m[54]};
      nop(1);
      start <= 0;
      nop(3);
      chk({CMD_ACTIVE, CMD_ABORT}, 2'b10);
      IRQ <= m[54:0];
      nop(4);
      chk(CMD_ACTIVE, 0);
      IRQ <= 0;
      rd(`FSC_ADDR_ABORT_LOC, 32'h100 + vec[i]);
    end
    rd(`FSC_ADDR_AEN_HIGH, 32'h400000);
    complete_run;
  end
endmodule
